/* File: src/dur_top.sv */
// two serial ports with party-line direction control on the second
//
// The plain strobed port and the address map were chosen for this implementation.
`include "dur_params.svh"
module dur_top #(
	parameter int FIFO_DEPTH = `DUR_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// host i/o port
	input  wire logic [15:0] ioAddr,
	input  wire logic [7:0]  ioWdata,
	input  wire logic        ioWr,
	input  wire logic        ioRd,
	output logic      [7:0]  ioRdata,
	// serial line inputs, index 0 first port
	input  wire logic [1:0]  serRx,
	input  wire logic [1:0]  serCts,
	input  wire logic [1:0]  serDsr,
	input  wire logic [1:0]  serDcd,
	input  wire logic [1:0]  serRi,
	// serial line outputs
	output logic      [1:0]  serTx,
	output logic      [1:0]  serRts,
	output logic      [1:0]  serDtr,
	// second port transceiver control
	output logic             drvEn485,
	output logic             fullDuplex485,
	// interrupt request pins
	output logic      [1:0]  irqOut,
	output logic      [1:0]  irqOe,
	// block interrupt
	output logic             intOut
);
	localparam logic [15:0] BASE1 = `DUR_PORT1_BASE;
	localparam logic [15:0] BASE2 = `DUR_PORT2_BASE;
	localparam logic [15:0] BASE3 = `DUR_PORT3_BASE;
	localparam logic [15:0] BASE4 = `DUR_PORT4_BASE;
	localparam int PB = `DUR_PARTY_BIT;

	logic [9:0] syncA;
	logic [9:0] syncB;
	logic [1:0] hit;
	logic [1:0] uartRts;
	logic [1:0] uartIrq;
	logic [1:0] irqPrev;
	logic [7:0] uartRd [2];
	logic [15:0] base [2];
	logic [7:0] ctrl, next_ctrl;
	logic [7:0] cfg, next_cfg;
	logic [2:0] evStat, next_evStat;
	logic [2:0] evEn, next_evEn;
	logic [2:0] evNew;
	logic [7:0] next_ioRdata;
	logic       next_drvEn485;
	logic       next_fullDuplex485;
	logic [1:0] next_irqOut;
	logic [1:0] next_irqOe;
	logic       next_intOut;
	logic       cfgTouched;

	// pin inputs pass two flops
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			// idle levels: receive lines high, modem inputs low
			syncA <= 10'h003;
			syncB <= 10'h003;
		end else begin
			syncA <= {serRi, serDcd, serDsr, serCts, serRx};
			syncB <= syncA;
		end
	end

	// address decode
	assign base[0] = cfg[`DUR_CFG_ALT1] ? BASE3 : BASE1;
	assign base[1] = cfg[`DUR_CFG_ALT2] ? BASE4 : BASE2;
	assign hit[0] = cfg[`DUR_CFG_EN1]
		&& ioAddr[15:3] == base[0][15:3];
	assign hit[1] = cfg[`DUR_CFG_EN2]
		&& ioAddr[15:3] == base[1][15:3];

	for (genvar p = 0; p < 2; p++) begin : g_port
		dur_uart #(
			.DEPTH(FIFO_DEPTH)
		) u_uart (
			.clk   (sys_clk),
			.nrst  (nrst),
			.regOff(ioAddr[2:0]),
			.wdata (ioWdata),
			.wr    (ioWr && hit[p]),
			.rd    (ioRd && hit[p]),
			.rdVal (uartRd[p]),
			.rx    (syncB[p]),
			.cts   (syncB[2+p]),
			.dsr   (syncB[4+p]),
			.dcd   (syncB[6+p]),
			.ri    (syncB[8+p]),
			.tx    (serTx[p]),
			.rts   (uartRts[p]),
			.dtr   (serDtr[p]),
			.irq   (uartIrq[p])
		);
	end

	assign serRts = uartRts;

	// events: port interrupt rises, transceiver starts driving
	assign evNew = {next_drvEn485 && !drvEn485, uartIrq & ~irqPrev};

	always_comb begin
		next_ctrl = ctrl;
		next_cfg = cfg;
		next_evEn = evEn;
		next_evStat = evStat;
		if (ioWr) begin
			if (ioAddr == `DUR_BOARD_CTRL)
				next_ctrl = ioWdata;
			if (ioAddr == `DUR_CFG)
				next_cfg = ioWdata;
			if (ioAddr == `DUR_EV_EN)
				next_evEn = ioWdata[2:0];
			if (ioAddr == `DUR_EV_CLR)
				next_evStat = evStat & ~ioWdata[2:0];
		end
		// a new event wins over a clear in the same cycle
		next_evStat = next_evStat | evNew;
	end

	always_comb begin
		next_ioRdata = 8'h00;
		if (ioRd) begin
			if (hit[0])
				next_ioRdata = uartRd[0];
			else if (hit[1])
				next_ioRdata = uartRd[1];
			else if (ioAddr == `DUR_BOARD_CTRL)
				next_ioRdata = ctrl;
			else if (ioAddr == `DUR_CFG)
				next_ioRdata = cfg;
			else if (ioAddr == `DUR_EV_STAT)
				next_ioRdata = {5'h00, evStat};
			else if (ioAddr == `DUR_EV_EN)
				next_ioRdata = {5'h00, evEn};
		end
	end

	always_comb begin
		next_drvEn485 = ctrl[PB] && uartRts[1];
		next_fullDuplex485 = !ctrl[PB];
		if (cfg[`DUR_CFG_POL]) begin
			next_irqOut = 2'b00;
			next_irqOe = uartIrq;
		end else begin
			next_irqOut = uartIrq;
			next_irqOe = 2'b11;
		end
		next_intOut = |(evStat & evEn);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= `DUR_CTRL_RST;
			cfg <= `DUR_CFG_RST;
			evStat <= 3'h0;
			evEn <= 3'h0;
			irqPrev <= 2'b00;
			ioRdata <= 8'h00;
			drvEn485 <= 1'b0;
			fullDuplex485 <= 1'b1;
			irqOut <= 2'b00;
			irqOe <= 2'b11;
			intOut <= 1'b0;
			cfgTouched <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			cfg <= next_cfg;
			evStat <= next_evStat;
			evEn <= next_evEn;
			irqPrev <= uartIrq;
			ioRdata <= next_ioRdata;
			drvEn485 <= next_drvEn485;
			fullDuplex485 <= next_fullDuplex485;
			irqOut <= next_irqOut;
			irqOe <= next_irqOe;
			intOut <= next_intOut;
			if (ioWr && ioAddr == `DUR_CFG)
				cfgTouched <= 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	sequence seqPartyWr;
		ioWr && ioAddr == `DUR_BOARD_CTRL && ioWdata[PB];
	endsequence

	sequence seqP1Read;
		ioRd && cfg[`DUR_CFG_EN1] && !cfg[`DUR_CFG_ALT1]
			&& ioAddr[15:3] == BASE1[15:3];
	endsequence

	sequence seqP2Read;
		ioRd && cfg[`DUR_CFG_EN2] && !cfg[`DUR_CFG_ALT2]
			&& ioAddr[15:3] == BASE2[15:3];
	endsequence

	chk_duplex_hold: assert property (
		!ctrl[PB] |=> fullDuplex485)
		else $error("full duplex lost without party-line mode");

	chk_party_entry: assert property (
		seqPartyWr |=> ctrl[PB] ##1 !fullDuplex485)
		else $error("party-line write did not take effect");

	chk_party_cause: assert property (
		$rose(ctrl[PB]) |-> $past(ioWr && ioAddr == `DUR_BOARD_CTRL))
		else $error("party-line mode entered without a host write");

	chk_dir_follow: assert property (
		(ctrl[PB] && uartRts[1]) |=> drvEn485)
		else $error("driver not enabled while rts asserted");

	chk_rx_default: assert property (
		!ctrl[PB] |=> !drvEn485)
		else $error("driver on outside party-line mode");

	chk_drv_rts: assert property (
		!uartRts[1] |=> !drvEn485)
		else $error("driver on without rts");

	chk_port1_map: assert property (
		seqP1Read |=> ioRdata == $past(uartRd[0]))
		else $error("first port not answering at its base");

	chk_port2_map: assert property (
		seqP2Read |=> ioRdata == $past(uartRd[1]))
		else $error("second port not answering at its base");

	chk_alt_map: assert property (
		(ioRd && cfg[`DUR_CFG_EN1] && cfg[`DUR_CFG_ALT1]
			&& ioAddr[15:3] == BASE3[15:3])
		|=> ioRdata == $past(uartRd[0]))
		else $error("alternative base not decoded");

	chk_enable_default: assert property (
		!cfgTouched |-> cfg[`DUR_CFG_EN1] && cfg[`DUR_CFG_EN2])
		else $error("port enable off before any setup");

	chk_irq_high: assert property (
		!cfg[`DUR_CFG_POL] |=> irqOe == 2'b11
			&& irqOut == $past(uartIrq))
		else $error("active-high interrupt pin wrong");

	chk_irq_low: assert property (
		cfg[`DUR_CFG_POL] |=> irqOut == 2'b00
			&& irqOe == $past(uartIrq))
		else $error("active-low interrupt pin wrong");

	chk_port2_alt: assert property (
		(ioRd && cfg[`DUR_CFG_EN2] && cfg[`DUR_CFG_ALT2]
			&& ioAddr[15:3] == BASE4[15:3])
		|=> ioRdata == $past(uartRd[1]))
		else $error("alternative base of second port not decoded");

	chk_port1_off: assert property (
		(ioRd && !cfg[`DUR_CFG_EN1] && ioAddr[15:3] == BASE1[15:3])
		|=> ioRdata == 8'h00)
		else $error("disabled first port still answers");

	chk_rdata_idle: assert property (
		!ioRd |=> ioRdata == 8'h00)
		else $error("read data not idle outside a read");

	chk_ctrl_hold: assert property (
		!(ioWr && ioAddr == `DUR_BOARD_CTRL) |=> ctrl == $past(ctrl))
		else $error("control register changed without a write");

	chk_duplex_party: assert property (
		ctrl[PB] |=> !fullDuplex485)
		else $error("full duplex kept in party-line mode");

	chk_drv_duplex: assert property (
		drvEn485 |-> !fullDuplex485)
		else $error("driver on while front end is full duplex");

	chk_drv_event: assert property (
		(next_drvEn485 && !drvEn485) |=> evStat[2])
		else $error("driver turn-on not recorded as event");
endmodule : dur_top

/* File: src/dur_params.svh */
// constants for the dual serial port block
`ifndef DUR_PARAMS_SVH
`define DUR_PARAMS_SVH
// host i/o bases of the serial ports
`define DUR_PORT1_BASE 16'h03f8
`define DUR_PORT2_BASE 16'h02f8
`define DUR_PORT3_BASE 16'h03e8
`define DUR_PORT4_BASE 16'h02e8
// board registers
`define DUR_BOARD_CTRL 16'h0090
`define DUR_CFG 16'h0091
`define DUR_EV_STAT 16'h0092
`define DUR_EV_CLR 16'h0093
`define DUR_EV_EN 16'h0094
// field positions
`define DUR_PARTY_BIT 3
`define DUR_CFG_EN1 0
`define DUR_CFG_EN2 1
`define DUR_CFG_ALT1 2
`define DUR_CFG_ALT2 3
`define DUR_CFG_POL 4
// reset values
`define DUR_CTRL_RST 8'h00
`define DUR_CFG_RST 8'h03
`define DUR_DLL_RST 8'h0c
// uart register offsets
`define DUR_R_DATA 3'h0
`define DUR_R_IER 3'h1
`define DUR_R_IIR 3'h2
`define DUR_R_LCR 3'h3
`define DUR_R_MCR 3'h4
`define DUR_R_LSR 3'h5
`define DUR_R_MSR 3'h6
`define DUR_R_SCR 3'h7
// interrupt identification codes
`define DUR_IID_LINE 4'h6
`define DUR_IID_RXD 4'h4
`define DUR_IID_THR 4'h2
`define DUR_IID_MDM 4'h0
`define DUR_IID_NONE 4'h1
`define DUR_FIFO_DEPTH 16
`endif

/* File: src/dur_pkg.sv */
// types shared by the dual serial port block
package dur_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_DATA  = 2'b10,
		ST_STOP  = 2'b11
	} dur_ser_e;
endpackage : dur_pkg

/* File: src/dur_uart.sv */
// one buffered asynchronous serial port, 8N1, 16x oversampling
`include "dur_params.svh"
module dur_uart #(
	parameter int DEPTH = `DUR_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// register access
	input  wire logic [2:0] regOff,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdVal,
	// synchronised line inputs
	input  wire logic       rx,
	input  wire logic       cts,
	input  wire logic       dsr,
	input  wire logic       dcd,
	input  wire logic       ri,
	// line outputs
	output logic            tx,
	output logic            rts,
	output logic            dtr,
	output logic            irq
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [7:0]  txMem [DEPTH];
	logic [7:0]  rxMem [DEPTH];
	logic [AW:0] txWp, txRp, rxWp, rxRp;
	logic [3:0]  ier, iid, mDelta, mPrev, mNow, txSub, rxSub;
	logic [7:0]  lcr, scr, dll, dlm, txSh, rxSh;
	logic [4:0]  mcr;
	logic [15:0] divCnt;
	logic [2:0]  txBit, rxBit;
	logic        fifoEn, oe, fe, thrPend, tick, dlab;
	logic        txEmpty, txFull, rxEmpty, rxFull;
	logic        thrWr, rxPop, txPop, rxPush;
	dur_pkg::dur_ser_e txSt, rxSt;

	assign dlab = lcr[7];
	assign txEmpty = txWp == txRp;
	assign rxEmpty = rxWp == rxRp;
	assign txFull = (txWp - txRp) == FULL;
	assign rxFull = (rxWp - rxRp) == FULL;
	assign thrWr = wr && regOff == `DUR_R_DATA && !dlab && !txFull;
	assign rxPop = rd && regOff == `DUR_R_DATA && !dlab && !rxEmpty;
	assign tick = divCnt == 16'h0000;
	assign txPop = tick && txSt == dur_pkg::ST_IDLE && !txEmpty;
	assign rxPush = tick && rxSt == dur_pkg::ST_STOP && rxSub == 4'hf;
	assign mNow = {dcd, ri, dsr, cts};

	// priority: line status, receive data, transmit empty, modem
	always_comb begin
		if ((oe || fe) && ier[2])
			iid = `DUR_IID_LINE;
		else if (!rxEmpty && ier[0])
			iid = `DUR_IID_RXD;
		else if (thrPend && ier[1])
			iid = `DUR_IID_THR;
		else if ((|mDelta) && ier[3])
			iid = `DUR_IID_MDM;
		else
			iid = `DUR_IID_NONE;
	end

	always_comb begin
		unique case (regOff)
		`DUR_R_DATA: rdVal = dlab ? dll : rxMem[rxRp[AW-1:0]];
		`DUR_R_IER:  rdVal = dlab ? dlm : {4'h0, ier};
		`DUR_R_IIR:  rdVal = {fifoEn, fifoEn, 2'b00, iid};
		`DUR_R_LCR:  rdVal = lcr;
		`DUR_R_MCR:  rdVal = {3'b000, mcr};
		`DUR_R_LSR:  rdVal = {1'b0, txEmpty && txSt == dur_pkg::ST_IDLE,
			txEmpty, 1'b0, fe, 1'b0, oe, !rxEmpty};
		`DUR_R_MSR:  rdVal = {mNow, mDelta};
		`DUR_R_SCR:  rdVal = scr;
		endcase
	end

	always_ff @(posedge clk) begin
		if (thrWr)
			txMem[txWp[AW-1:0]] <= wdata;
		if (rxPush && !rxFull)
			rxMem[rxWp[AW-1:0]] <= rxSh;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txWp <= '0; txRp <= '0; rxWp <= '0; rxRp <= '0;
			ier <= 4'h0; lcr <= 8'h00; scr <= 8'h00; mcr <= 5'h00;
			dll <= `DUR_DLL_RST; dlm <= 8'h00; fifoEn <= 1'b0;
			oe <= 1'b0; fe <= 1'b0; thrPend <= 1'b0;
			mDelta <= 4'h0; mPrev <= 4'h0; divCnt <= 16'h0000;
			txSt <= dur_pkg::ST_IDLE; rxSt <= dur_pkg::ST_IDLE;
			txSub <= 4'h0; rxSub <= 4'h0; txBit <= 3'h0; rxBit <= 3'h0;
			txSh <= 8'h00; rxSh <= 8'h00;
			tx <= 1'b1; rts <= 1'b0; dtr <= 1'b0; irq <= 1'b0;
		end else begin
			divCnt <= !tick ? divCnt - 16'h0001 :
				({dlm, dll} == 16'h0000 ? 16'h0000 : {dlm, dll} - 16'h0001);
			if (wr) begin
				unique case (regOff)
				`DUR_R_DATA: if (dlab) dll <= wdata;
				`DUR_R_IER:  if (dlab) dlm <= wdata; else ier <= wdata[3:0];
				`DUR_R_IIR: begin
					fifoEn <= wdata[0];
					if (wdata[1]) rxWp <= rxRp;
					if (wdata[2]) txWp <= txRp;
				end
				`DUR_R_LCR:  lcr <= wdata;
				`DUR_R_MCR:  mcr <= wdata[4:0];
				`DUR_R_SCR:  scr <= wdata;
				default: ;
				endcase
			end
			if (thrWr)
				txWp <= txWp + 1'b1;
			if (rxPop)
				rxRp <= rxRp + 1'b1;
			// clears first so that a same-cycle event wins
			if (rd && regOff == `DUR_R_LSR) begin
				oe <= 1'b0;
				fe <= 1'b0;
			end
			if (thrWr || (rd && regOff == `DUR_R_IIR && iid == `DUR_IID_THR))
				thrPend <= 1'b0;
			if (txPop && (txWp - txRp) == (AW+1)'(1) && !thrWr)
				thrPend <= 1'b1;
			mPrev <= mNow;
			mDelta <= ((rd && regOff == `DUR_R_MSR) ? 4'h0 : mDelta)
				| (mNow ^ mPrev);
			if (tick) begin
				unique case (txSt)
				dur_pkg::ST_IDLE: if (!txEmpty) begin
					txSh <= txMem[txRp[AW-1:0]];
					txRp <= txRp + 1'b1;
					txSt <= dur_pkg::ST_START;
					txSub <= 4'h0;
					tx <= 1'b0;
				end
				dur_pkg::ST_START: begin
					txSub <= txSub + 4'h1;
					if (txSub == 4'hf) begin
						txSt <= dur_pkg::ST_DATA;
						tx <= txSh[0];
						txBit <= 3'h0;
					end
				end
				dur_pkg::ST_DATA: begin
					txSub <= txSub + 4'h1;
					if (txSub == 4'hf) begin
						if (txBit == 3'h7) begin
							txSt <= dur_pkg::ST_STOP;
							tx <= 1'b1;
						end else begin
							txBit <= txBit + 3'h1;
							txSh <= txSh >> 1;
							tx <= txSh[1];
						end
					end
				end
				dur_pkg::ST_STOP: begin
					txSub <= txSub + 4'h1;
					if (txSub == 4'hf)
						txSt <= dur_pkg::ST_IDLE;
				end
				endcase
				unique case (rxSt)
				dur_pkg::ST_IDLE: if (!rx) begin
					rxSt <= dur_pkg::ST_START;
					rxSub <= 4'h0;
				end
				dur_pkg::ST_START: begin
					rxSub <= rxSub + 4'h1;
					if (rxSub == 4'h7) begin
						rxSt <= rx ? dur_pkg::ST_IDLE : dur_pkg::ST_DATA;
						rxSub <= 4'h0;
						rxBit <= 3'h0;
					end
				end
				dur_pkg::ST_DATA: begin
					rxSub <= rxSub + 4'h1;
					if (rxSub == 4'hf) begin
						rxSh <= {rx, rxSh[7:1]};
						rxBit <= rxBit + 3'h1;
						if (rxBit == 3'h7)
							rxSt <= dur_pkg::ST_STOP;
					end
				end
				dur_pkg::ST_STOP: begin
					rxSub <= rxSub + 4'h1;
					if (rxSub == 4'hf) begin
						rxSt <= dur_pkg::ST_IDLE;
						if (!rx)
							fe <= 1'b1;
						if (rxFull)
							oe <= 1'b1;
						else
							rxWp <= rxWp + 1'b1;
					end
				end
				endcase
			end
			rts <= mcr[1];
			dtr <= mcr[0];
			irq <= !iid[0];
		end
	end

	chk_fifo_bound: assert property (@(posedge clk) disable iff (!nrst)
		(txWp - txRp) <= FULL && (rxWp - rxRp) <= FULL)
		else $error("fifo holds more than its depth");
endmodule : dur_uart

/* File: test/dur_serial_peer.sv */
// far-end serial equipment: receives a frame, then echoes it back
module dur_serial_peer #(
	parameter int BIT = 16
) (
	// clock
	input  wire logic       clk,
	// line from the block
	input  wire logic       txLine,
	// line to the block
	output logic            rxLine,
	// last byte received
	output logic      [7:0] lastByte
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] shiftIn;

	initial begin
		rxLine = 1'b1;
		lastByte = 8'h00;
		shiftIn = 8'h00;
		forever begin
			@(negedge txLine);
			// sample in the middle of each bit, lsb first
			repeat (BIT / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk);
				shiftIn[i] = txLine;
			end
			repeat (BIT) @(posedge clk);
			lastByte = shiftIn;
			// echo: start, eight data bits lsb first, stop
			@(posedge clk);
			rxLine <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk);
				rxLine <= shiftIn[i];
			end
			repeat (BIT) @(posedge clk);
			rxLine <= 1'b1;
			repeat (BIT) @(posedge clk);
		end
	end
endmodule : dur_serial_peer

/* File: test/test_dual_uart_rs485_direction.sv */
// self-checking bench for the dual serial port block
`include "dur_params.svh"
module test_dual_uart_rs485_direction;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk;
	logic        nrst;
	logic [15:0] ioAddr;
	logic [7:0]  ioWdata;
	logic        ioWr;
	logic        ioRd;
	logic [7:0]  ioRdata;
	wire  [1:0]  serRx;
	logic [1:0]  serCts;
	logic [1:0]  serDsr;
	logic [1:0]  serDcd;
	logic [1:0]  serRi;
	logic [1:0]  serTx;
	logic [1:0]  serRts;
	logic [1:0]  serDtr;
	logic        drvEn485;
	logic        fullDuplex485;
	logic [1:0]  irqOut;
	logic [1:0]  irqOe;
	logic        intOut;
	logic [7:0]  peerByte [2];
	int          err_total;
	int          checks;

	dur_top dur_top_i (
		.sys_clk(sys_clk), .nrst(nrst), .ioAddr(ioAddr),
		.ioWdata(ioWdata), .ioWr(ioWr), .ioRd(ioRd), .ioRdata(ioRdata),
		.serRx(serRx), .serCts(serCts), .serDsr(serDsr),
		.serDcd(serDcd), .serRi(serRi), .serTx(serTx),
		.serRts(serRts), .serDtr(serDtr), .drvEn485(drvEn485),
		.fullDuplex485(fullDuplex485), .irqOut(irqOut), .irqOe(irqOe),
		.intOut(intOut)
	);
	dur_serial_peer peer0_i (.clk(sys_clk), .txLine(serTx[0]),
		.rxLine(serRx[0]), .lastByte(peerByte[0]));
	dur_serial_peer peer1_i (.clk(sys_clk), .txLine(serTx[1]),
		.rxLine(serRx[1]), .lastByte(peerByte[1]));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic print_verdict();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr_io(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		ioAddr <= a;
		ioWdata <= d;
		ioWr <= 1'b1;
		@(posedge sys_clk);
		ioWr <= 1'b0;
	endtask : wr_io

	task automatic rd_io(input logic [15:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		ioAddr <= a;
		ioRd <= 1'b1;
		@(posedge sys_clk);
		ioRd <= 1'b0;
		#1 d = ioRdata;
	endtask : rd_io

	task automatic rd_chk(input string what, input logic [15:0] a,
			input logic [7:0] exp);
		logic [7:0] v;
		rd_io(a, v);
		chk(what, v, exp);
	endtask : rd_chk

	// hang guard
	initial begin
		repeat (100000) @(posedge sys_clk);
		err_total++;
		print_verdict();
	end

	initial begin
		logic [15:0] base;
		logic [7:0]  v;
		logic [7:0]  txv [2];
		int          n;
		txv[0] = 8'h55;
		txv[1] = 8'ha3;
		err_total = 0;
		checks = 0;
		nrst = 1'b0;
		ioAddr = 16'h0000;
		ioWdata = 8'h00;
		ioWr = 1'b0;
		ioRd = 1'b0;
		serCts = 2'h0;
		serDsr = 2'h0;
		serDcd = 2'h0;
		serRi = 2'h0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk("fullDuplex485", {7'h00, fullDuplex485}, 8'h01);
		chk("drvEn485", {7'h00, drvEn485}, 8'h00);
		chk("irqOut", {6'h00, irqOut}, 8'h00);
		chk("irqOe", {6'h00, irqOe}, 8'h03);
		rd_chk("config", `DUR_CFG, 8'h03);
		rd_chk("lsr port1", `DUR_PORT1_BASE + 16'h5, 8'h60);
		rd_chk("lsr port2", `DUR_PORT2_BASE + 16'h5, 8'h60);
		rd_chk("alt3 off", `DUR_PORT3_BASE + 16'h5, 8'h00);
		rd_chk("alt4 off", `DUR_PORT4_BASE + 16'h5, 8'h00);
		wr_io(`DUR_CFG, 8'h0f);
		rd_chk("alt3 on", `DUR_PORT3_BASE + 16'h5, 8'h60);
		rd_chk("alt4 on", `DUR_PORT4_BASE + 16'h5, 8'h60);
		rd_chk("port1 moved", `DUR_PORT1_BASE + 16'h5, 8'h00);
		wr_io(`DUR_CFG, 8'h02);
		rd_chk("port1 off", `DUR_PORT1_BASE + 16'h5, 8'h00);
		wr_io(`DUR_CFG, 8'h03);
		// rts before party-line mode must not turn the driver on
		wr_io(`DUR_EV_EN, 8'h07);
		wr_io(`DUR_PORT2_BASE + 16'h4, 8'h02);
		repeat (3) @(posedge sys_clk);
		#1;
		chk("drv before mode", {7'h00, drvEn485}, 8'h00);
		chk("rts2", {6'h00, serRts}, 8'h02);
		chk("dtr", {6'h00, serDtr}, 8'h00);
		chk("duplex before mode", {7'h00, fullDuplex485}, 8'h01);
		wr_io(`DUR_BOARD_CTRL, 8'h08);
		repeat (3) @(posedge sys_clk);
		#1;
		chk("duplex party", {7'h00, fullDuplex485}, 8'h00);
		chk("drv follows rts", {7'h00, drvEn485}, 8'h01);
		chk("intOut drv rise", {7'h00, intOut}, 8'h01);
		rd_chk("event drv", `DUR_EV_STAT, 8'h04);
		wr_io(`DUR_EV_CLR, 8'h04);
		wr_io(`DUR_PORT2_BASE + 16'h4, 8'h00);
		repeat (3) @(posedge sys_clk);
		#1;
		chk("drv rts low", {7'h00, drvEn485}, 8'h00);
		chk("rts2 low", {6'h00, serRts}, 8'h00);
		chk("intOut cleared", {7'h00, intOut}, 8'h00);
		wr_io(`DUR_BOARD_CTRL, 8'h00);
		// one frame out and back on each port, fastest divisor
		for (int p = 0; p < 2; p++) begin
			base = (p == 0) ? `DUR_PORT1_BASE : `DUR_PORT2_BASE;
			wr_io(base + 16'h3, 8'h80);
			wr_io(base, 8'h00);
			wr_io(base + 16'h1, 8'h00);
			wr_io(base + 16'h3, 8'h03);
			wr_io(base + 16'h1, 8'h01);
			wr_io(base, txv[p]);
			v = 8'h00;
			for (n = 0; n < 800 && v[0] !== 1'b1; n++)
				rd_io(base + 16'h5, v);
			if (n == 800) begin
				err_total++;
				print_verdict();
			end
			chk("peer byte", peerByte[p], txv[p]);
			// pin lags data ready by two registers
			repeat (2) @(posedge sys_clk);
			#1;
			chk("irq high", {7'h00, irqOut[p]}, 8'h01);
			wr_io(`DUR_CFG, 8'h13);
			repeat (2) @(posedge sys_clk);
			#1;
			chk("irq low pol", {7'h00, irqOut[p]}, 8'h00);
			chk("irq oe pol", {7'h00, irqOe[p]}, 8'h01);
			wr_io(`DUR_CFG, 8'h03);
			rd_chk("echo byte", base, txv[p]);
		end
		rd_chk("events ports", `DUR_EV_STAT, 8'h03);
		wr_io(`DUR_EV_CLR, 8'h03);
		rd_chk("events clear", `DUR_EV_STAT, 8'h00);
		chk("intOut idle", {7'h00, intOut}, 8'h00);
		print_verdict();
	end
endmodule : test_dual_uart_rs485_direction
